// [ps2m_port.sv]
// Purpose: apb register block for a ps/2 pointer channel
// Assumes: open-drain pins resolved outside; oe low means driving
// Notes:   zero-wait apb slave; one level interrupt
// Contract
// R1 - clock pin sampled only while clock input enable is one; pin always synchronised, only the receiver is gated
// R2 - clock pin driven only while clock output enable is one or a received byte holds it low
// R3 - data pin driven only while data output enable is one
// R4 - enabled clock output follows the clock drive level bit
// R5 - clock pin level readable in bit 10
// R6 - data pin level readable in bit 9
// R7 - received parity in read-only bit 8
// R8 - received byte in read-only bits 7 to 0
// R9 - status bit 0 flags a complete received byte
// R10 - full byte sets the flag and requests an interrupt
// R11 - flag set forces the clock line low
// R12 - writing one clears the flag and withdraws the interrupt
// R13 - one interrupt per received byte
// R14 - frame is start, eight data lsb first, parity, stop
// R15 - nine bits have odd parity; software asks resend on error
// R16 - clock input enable clears itself after each byte
// R17 - enabled data output follows the data drive level bit
// R18 - status bits 15 to 1 read zero, writes ignored
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
module ps2m_port (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_clk_in,
	output logic             o_clk_out,
	output logic             o_clk_oe_n,
	input  wire logic        i_dat_in,
	output logic             o_dat_out,
	output logic             o_dat_oe_n,
	output logic             o_irq
);
	logic        clk_input_enable;
	logic        clk_output_enable;
	logic        dat_output_enable;
	logic        clk_drive_level;
	logic        dat_drive_level;
	logic        rx_full_flag;
	logic        rx_full_mask;
	logic        clk_pin_level;
	logic        dat_pin_level;
	logic        rx_done;
	logic [8:0]  rx_word;
	logic        wr_en;
	logic        rd_en;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        hit_mask;
	logic [15:0] ctrl_view;

	// ==========================================================
	// pin synchronisers
	ps2m_sync u_sync_clk (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_async   (i_clk_in),
		.o_sync    (clk_pin_level)
	);
	ps2m_sync u_sync_dat (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_async   (i_dat_in),
		.o_sync    (dat_pin_level)
	);

	// ==========================================================
	// receiver
	ps2m_rx u_rx (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_enable  (clk_input_enable), // see R1
		.i_clk_lvl (clk_pin_level),
		.i_dat_lvl (dat_pin_level),
		.o_done    (rx_done),
		.o_word    (rx_word)
	);

	// ==========================================================
	// apb decode
	assign hit_ctrl = (i_paddr == ps2m_pkg::ADDR_CTRL);
	assign hit_stat = (i_paddr == ps2m_pkg::ADDR_STAT);
	assign hit_mask = (i_paddr == ps2m_pkg::ADDR_MASK);
	assign wr_en    = i_psel & i_penable & i_pwrite;
	assign rd_en    = i_psel & ~i_penable & ~i_pwrite;
	assign o_pready = 1'b1;

	assign ctrl_view = {clk_input_enable, clk_output_enable,
		dat_output_enable, clk_drive_level, dat_drive_level,
		clk_pin_level, // see R5
		dat_pin_level, // see R6
		rx_word};      // see R7 see R8

	// ==========================================================
	// control bits
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_input_enable  <= 1'b0;
			clk_output_enable <= 1'b0;
			dat_output_enable <= 1'b0;
			clk_drive_level   <= 1'b0;
			dat_drive_level   <= 1'b0;
		end else begin
			if (wr_en && hit_ctrl) begin
				clk_input_enable  <= i_pwdata[ps2m_pkg::BIT_CIE];
				clk_output_enable <= i_pwdata[ps2m_pkg::BIT_COE];
				dat_output_enable <= i_pwdata[ps2m_pkg::BIT_DOE];
				clk_drive_level   <= i_pwdata[ps2m_pkg::BIT_CDL];
				dat_drive_level   <= i_pwdata[ps2m_pkg::BIT_DDL];
			end
			// hardware clear beats a same-cycle software set
			if (rx_done) begin
				clk_input_enable <= 1'b0; // see R16
			end
		end
	end

	// ==========================================================
	// status and mask
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_full_flag <= 1'b0;
		end else if (rx_done) begin
			rx_full_flag <= 1'b1; // see R9 see R10 see R13
		end else if (wr_en && hit_stat
				&& i_pwdata[ps2m_pkg::BIT_FULL]) begin
			rx_full_flag <= 1'b0; // see R12
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_full_mask <= 1'b0;
		end else if (wr_en && hit_mask) begin
			rx_full_mask <= i_pwdata[ps2m_pkg::BIT_FULL];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= rx_full_flag & rx_full_mask; // see R10 see R12
		end
	end

	// ==========================================================
	// read data, captured in the setup phase
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (i_psel && !i_penable) begin
			o_pslverr <= ~(hit_ctrl | hit_stat | hit_mask);
			o_prdata  <= 32'h0000_0000;
			if (rd_en && hit_ctrl) begin
				o_prdata <= {16'h0000, ctrl_view};
			end else if (rd_en && hit_stat) begin
				o_prdata <= {31'h0000_0000, rx_full_flag}; // see R18
			end else if (rd_en && hit_mask) begin
				o_prdata <= {31'h0000_0000, rx_full_mask};
			end
		end
	end

	// ==========================================================
	// pin drivers; a full buffer holds the clock low
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_clk_out  <= 1'b1;
			o_clk_oe_n <= 1'b1;
			o_dat_out  <= 1'b1;
			o_dat_oe_n <= 1'b1;
		end else begin
			if (rx_done || rx_full_flag) begin
				o_clk_out  <= 1'b0; // see R11
				o_clk_oe_n <= 1'b0; // see R11
			end else begin
				o_clk_out  <= clk_drive_level;    // see R4
				o_clk_oe_n <= ~clk_output_enable; // see R2
			end
			o_dat_out  <= dat_drive_level;    // see R17
			o_dat_oe_n <= ~dat_output_enable; // see R3
		end
	end
endmodule // ps2m_port

// [ps2m_pkg.sv]
// Purpose: constants for the pointer channel register block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   16-bit registers sit in the low half of the word
package ps2m_pkg;
	// ==========================================================
	// register map
	localparam logic [31:0] ADDR_CTRL = 32'h1000DC10;
	localparam logic [31:0] ADDR_STAT = 32'h1000DC14;
	localparam logic [31:0] ADDR_MASK = 32'h1000DC18;
	localparam logic [11:0] OFS_MASK  = 12'hC18;
	// ==========================================================
	// register fields and receive constants
	localparam int BIT_CIE = 15;
	localparam int BIT_COE = 14;
	localparam int BIT_DOE = 13;
	localparam int BIT_CDL = 12;
	localparam int BIT_DDL = 11;
	localparam int BIT_CPL = 10;
	localparam int BIT_DPL = 9;
	localparam int BIT_PAR = 8;
	localparam int BIT_FULL = 0;
	localparam int FRAME_BITS = 11;
	localparam logic [3:0] CNT_LAST = 4'hA;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [8:0] SHIFT_RST = 9'h000;
	typedef enum logic [1:0] {
		PS2M_IDLE = 2'b00,
		PS2M_SHIFT = 2'b01,
		PS2M_HOLD = 2'b11
	} ps2m_state_t;
endpackage

// [ps2m_sync.sv]
// Purpose: two-flop synchroniser for a pin level
// Assumes: input asynchronous to i_clk_sys
// Notes:   reset value is the idle-high line level
`timescale 1ns/1ns
module ps2m_sync (
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta;
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta   <= 1'b1;
			o_sync <= 1'b1;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule // ps2m_sync

// [ps2m_rx.sv]
// Purpose: receive shifter for one pointer frame
// Assumes: synchronised clock and data levels
// Notes:   samples data on each falling clock edge
`timescale 1ns/1ns
module ps2m_rx (
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	input  wire logic       i_enable,
	input  wire logic       i_clk_lvl,
	input  wire logic       i_dat_lvl,
	output logic            o_done,
	output logic [8:0]      o_word
);
	ps2m_pkg::ps2m_state_t state;
	logic       clk_prev;
	logic [3:0] count;
	logic       fall;
	assign fall = clk_prev & ~i_clk_lvl;
	// ==========================================================
	// edge finder
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_prev <= 1'b1;
		end else begin
			clk_prev <= i_clk_lvl;
		end
	end
	// ==========================================================
	// frame: start, eight data lsb first, parity, stop
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state  <= ps2m_pkg::PS2M_IDLE;
			count  <= ps2m_pkg::CNT_ZERO;
			o_word <= ps2m_pkg::SHIFT_RST;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (state)
			ps2m_pkg::PS2M_IDLE: begin
				count <= ps2m_pkg::CNT_ZERO;
				if (i_enable && fall && !i_dat_lvl) begin
					state <= ps2m_pkg::PS2M_SHIFT; // see R14
					count <= 4'h1;
				end
			end
			ps2m_pkg::PS2M_SHIFT: begin
				if (!i_enable) begin
					state <= ps2m_pkg::PS2M_IDLE;
				end else if (fall) begin
					count <= count + 4'h1;
					if (count == ps2m_pkg::CNT_LAST) begin
						state  <= ps2m_pkg::PS2M_HOLD; // see R14
						o_done <= 1'b1;
					end else begin
						o_word <= {i_dat_lvl, o_word[8:1]}; // see R14
					end
				end
			end
			ps2m_pkg::PS2M_HOLD: begin
				// wait for the input enable to clear before returning to idle
				if (!i_enable) begin
					state <= ps2m_pkg::PS2M_IDLE;
				end
			end
			default: begin
				state <= ps2m_pkg::PS2M_IDLE;
			end
			endcase
		end
	end
endmodule // ps2m_rx

// [ps2m_port_properties.sv]
// Purpose: port-level checks for the pointer channel
// Assumes: bench writes no control word while a masked byte is held
// Notes:   flag is seen only through o_irq
`timescale 1ns/1ns
module ps2m_port_properties (
	input wire logic        i_clk_sys,
	input wire logic        i_reset_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_clk_out,
	input wire logic        o_clk_oe_n,
	input wire logic        o_dat_out,
	input wire logic        o_dat_oe_n,
	input wire logic        o_irq
);
	// ==========================================================
	// decode
	logic acc, wr_c, wr_s;
	assign acc = i_psel && i_penable;
	assign wr_c = acc && i_pwrite && i_paddr == ps2m_pkg::ADDR_CTRL;
	assign wr_s = acc && i_pwrite && (i_paddr == ps2m_pkg::ADDR_STAT
		|| i_paddr == ps2m_pkg::ADDR_MASK);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// ==========================================================
	// properties
	property p_hold_low;
		o_irq |-> !o_clk_oe_n && !o_clk_out;
	endproperty
	property p_clk_rel;
		wr_c && !i_pwdata[14] && !o_irq |-> ##[1:2] o_clk_oe_n;
	endproperty
	property p_clk_drv;
		wr_c && i_pwdata[14] && i_pwdata[12] && !o_irq
			|-> ##[1:2] !o_clk_oe_n && o_clk_out;
	endproperty
	property p_dat_rel;
		wr_c && !i_pwdata[13] |-> ##[1:2] o_dat_oe_n;
	endproperty
	property p_dat_hi;
		wr_c && i_pwdata[13] && i_pwdata[11]
			|-> ##[1:2] !o_dat_oe_n && o_dat_out;
	endproperty
	property p_dat_lo;
		wr_c && i_pwdata[13] && !i_pwdata[11]
			|-> ##[1:2] !o_dat_oe_n && !o_dat_out;
	endproperty
	property p_irq_clr;
		wr_s && i_paddr == ps2m_pkg::ADDR_STAT && i_pwdata[0]
			|-> ##[1:2] !o_irq;
	endproperty
	property p_irq_stay;
		o_irq && !wr_s && !$past(wr_s) |=> o_irq;
	endproperty
	property p_stat_zero;
		acc && !i_pwrite && i_paddr == ps2m_pkg::ADDR_STAT
			|-> o_prdata[31:1] == 31'h00000000;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("clock not held");
	a_clk_rel: assert property (p_clk_rel) else $error("clock driven");
	a_clk_drv: assert property (p_clk_drv) else $error("clock level");
	a_dat_rel: assert property (p_dat_rel) else $error("data driven");
	a_dat_hi: assert property (p_dat_hi) else $error("data not high");
	a_dat_lo: assert property (p_dat_lo) else $error("data not low");
	a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
	a_irq_stay: assert property (p_irq_stay) else $error("irq lost");
	a_stat_zero: assert property (p_stat_zero) else $error("stat bits");
	c_irq: cover property ($rose(o_irq));
	c_clr: cover property (wr_s && i_pwdata[0] && o_irq);
	c_drv: cover property (wr_c && i_pwdata[14]);
endmodule // ps2m_port_properties
bind ps2m_port ps2m_port_properties u_props (.i_clk_sys, .i_reset_n,
	.i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
	.o_clk_out, .o_clk_oe_n, .o_dat_out, .o_dat_oe_n, .o_irq);

// [ps2m_mouse.sv]
// Purpose: behavioural pointer device on open-drain lines
// Assumes: lines pulled up; 64 ns link clock inside frames only
// Notes:   flip asks for a wrong parity bit
`timescale 1ns/1ns
module ps2m_mouse (
	input  wire logic i_clk_line,
	output logic      o_clk_low,
	output logic      o_dat_low
);
	initial begin
		o_clk_low = 1'b0;
		o_dat_low = 1'b0;
	end
	task automatic send(input logic [7:0] b, input logic flip);
		logic [10:0] f;
		f = {1'b1, ~^b ^ flip, b, 1'b0};
		// an inhibited line means no frame may start
		wait (i_clk_line);
		// keep every line change clear of a system clock edge
		#3;
		for (int i = 0; i < 11; i++) begin
			o_dat_low = !f[i];
			#32 o_clk_low = 1'b1;
			#32 o_clk_low = 1'b0;
		end
		o_dat_low = 1'b0;
	endtask
endmodule // ps2m_mouse

// [ps2m_port_tb_top.sv]
// Purpose: self-checking bench for the pointer channel port
// Assumes: wire-and of both parties with pull-ups
// Notes:   table covers pin control, hand tests cover receive
`timescale 1ns/1ns
module ps2m_port_tb_top;
	// ==========================================================
	// signals
	logic        i_clk_sys = 1'b0, i_reset_n = 1'b0;
	logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [31:0] i_paddr = 32'h00000000, i_pwdata = 32'h00000000;
	logic [31:0] o_prdata, rd;
	logic        o_pready, o_pslverr, o_clk_out, o_clk_oe_n, err;
	logic        o_dat_out, o_dat_oe_n, o_irq, i_clk_in, i_dat_in;
	logic        m_clk_low, m_dat_low;
	int          num_errors = 0, num_checks = 0;
	// {wdata, clk oe_n, clk oe_n|out, dat oe_n, dat oe_n|out, levels}
	logic [21:0] rows [5] = '{22'h10000D, 22'h14001F, 22'h0A0037,
		22'h080032, 22'h07FFFF};
	always #4 i_clk_sys = ~i_clk_sys;
	assign i_clk_in = !((!o_clk_oe_n && !o_clk_out) || m_clk_low);
	assign i_dat_in = !((!o_dat_oe_n && !o_dat_out) || m_dat_low);
	ps2m_port DUT (.i_clk_sys, .i_reset_n, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_clk_in, .o_clk_out, .o_clk_oe_n, .i_dat_in, .o_dat_out,
		.o_dat_oe_n, .o_irq);
	ps2m_mouse u_mouse (.i_clk_line(i_clk_in), .o_clk_low(m_clk_low),
		.o_dat_low(m_dat_low));
	// ==========================================================
	// tasks
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do @(posedge i_clk_sys); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic chk(input logic [15:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// sequence
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		@(posedge i_clk_sys);
		chk(16'({o_irq, o_clk_oe_n, o_dat_oe_n}), 16'h0003, "reset");
		apb(0, ps2m_pkg::ADDR_STAT, 0);
		chk(rd[15:0], 16'h0000, "stat reset");
		apb(0, 32'h1000DC1C, 0);
		chk(rd[15:0], 16'h0000, "unmapped data");
		chk(16'(err), 16'h0001, "unmapped error");
		foreach (rows[i]) begin
			apb(1, ps2m_pkg::ADDR_CTRL, 32'(rows[i][21:6]));
			repeat (4) @(posedge i_clk_sys);
			chk(16'({o_clk_oe_n, o_clk_oe_n | o_clk_out, o_dat_oe_n,
				o_dat_oe_n | o_dat_out}), 16'(rows[i][5:2]), "pins");
			apb(0, ps2m_pkg::ADDR_CTRL, 0);
			chk(16'(rd[15:9]), 16'({rows[i][21:17], rows[i][1:0]}), "ctrl");
		end
		apb(1, ps2m_pkg::ADDR_MASK, 1);
		apb(1, ps2m_pkg::ADDR_CTRL, 32'h00008000);
		u_mouse.send(8'hA5, 1'b0);
		for (int n = 0; n < 300 && o_irq !== 1'b1; n++) @(posedge i_clk_sys);
		chk(16'({o_irq, o_clk_oe_n, o_clk_out}), 16'h0004, "held");
		apb(0, ps2m_pkg::ADDR_CTRL, 0);
		chk(rd[15:0] & 16'h81FF, 16'h01A5, "byte");
		apb(1, ps2m_pkg::ADDR_CTRL, 32'h000000FF);
		apb(0, ps2m_pkg::ADDR_CTRL, 0);
		chk(16'(rd[8:0]), 16'h01A5, "ro write");
		apb(0, ps2m_pkg::ADDR_STAT, 0);
		chk(rd[15:0], 16'h0001, "flag");
		apb(1, ps2m_pkg::ADDR_STAT, 32'h0000FFFF);
		repeat (3) @(posedge i_clk_sys);
		chk(16'({o_irq, o_clk_oe_n}), 16'h0001, "cleared");
		// masked byte with a bad parity bit: stored as sent
		apb(1, ps2m_pkg::ADDR_MASK, 0);
		apb(1, ps2m_pkg::ADDR_CTRL, 32'h00008000);
		u_mouse.send(8'h3C, 1'b1);
		repeat (20) @(posedge i_clk_sys);
		chk(16'(o_irq), 16'h0000, "masked");
		apb(0, ps2m_pkg::ADDR_CTRL, 0);
		chk(16'(rd[8:0]), 16'h003C, "parity");
		apb(1, ps2m_pkg::ADDR_MASK, 1);
		repeat (3) @(posedge i_clk_sys);
		chk(16'(o_irq), 16'h0001, "unmasked");
		apb(1, ps2m_pkg::ADDR_STAT, 1);
		repeat (3) @(posedge i_clk_sys);
		u_mouse.send(8'h55, 1'b0);
		repeat (20) @(posedge i_clk_sys);
		apb(0, ps2m_pkg::ADDR_STAT, 0);
		chk(rd[15:0], 16'h0000, "ignored");
		give_verdict();
	end
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
endmodule // ps2m_port_tb_top
